/* File: hdl/crs_consts.vh */
// crs_consts.vh: constants for the core register set and return stack
// assumes inclusion by bare name from every design file
`ifndef CRS_CONSTS_VH
`define CRS_CONSTS_VH
// data-space addresses of the mirrored registers
`define CRS_ADDR_PTR0 8'h80
`define CRS_ADDR_PTR1 8'h81
`define CRS_ADDR_SD0 8'h82
`define CRS_ADDR_SD1 8'h83
`define CRS_ADDR_ACC 8'hFF
// widths and depths
`define CRS_DW 8
`define CRS_PCW 12
`define CRS_DEPTH 6
// reset values and the pc step
`define CRS_RESET_VECTOR 12'hFFE
`define CRS_ZERO8 8'h00
`define CRS_ZERO12 12'h000
`define CRS_PC_STEP 12'h001
// program counter update sources
`define CRS_PC_HOLD 3'h0
`define CRS_PC_INC 3'h1
`define CRS_PC_JUMP 3'h2
`define CRS_PC_CALL 3'h3
`define CRS_PC_REL 3'h4
`define CRS_PC_IRQ 3'h5
`define CRS_PC_NMI 3'h6
`define CRS_PC_RET 3'h7
// flag contexts
`define CRS_CTX_NORM 2'h0
`define CRS_CTX_IRQ 2'h1
`define CRS_CTX_NMI 2'h2
`endif

/* File: hdl/crs_stack.v */
// crs_stack.v: six-level shifting return-address stack, no pointer
// assumes push and pop never together; enable freezes everything
`timescale 1ns/10ps
`include "crs_consts.vh"
module crs_stack #(
	parameter W = `CRS_PCW,
	parameter DEPTH = `CRS_DEPTH
) (
	// clock and reset
	input wire clk,
	input wire resetn,
	input wire ce,
	// push with data, pop
	input wire push,
	input wire [W-1:0] push_data,
	input wire pop,
	// top level and fill count
	output reg [W-1:0] top_reg,
	output reg [3:0] depth_reg
);
	reg [W-1:0] lvl [0:DEPTH-1];
	integer i;

	// levels shift up on push, down on pop; emptied by reset
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			for (i = 0; i < DEPTH; i = i + 1) begin
				lvl[i] <= `CRS_ZERO12;
			end
			depth_reg <= 4'h0;
		end else if (ce) begin
			if (push) begin
				// oldest level falls off the end
				for (i = DEPTH - 1; i > 0; i = i - 1) begin
					lvl[i] <= lvl[i-1];
				end
				lvl[0] <= push_data;
				if (depth_reg != DEPTH[3:0])
					depth_reg <= depth_reg + 4'h1;
			end else if (pop) begin
				// each remaining level moves down one
				for (i = 0; i < DEPTH - 1; i = i + 1) begin
					lvl[i] <= lvl[i+1];
				end
				// count of an empty stack stays at zero
				if (depth_reg != 4'h0)
					depth_reg <= depth_reg - 4'h1;
			end
		end
	end

	// registered view of level zero, the top, for the pop path
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			top_reg <= `CRS_ZERO12;
		end else if (ce) begin
			if (push)
				top_reg <= push_data;
			else if (pop)
				top_reg <= lvl[1];
		end
	end
endmodule

/* File: hdl/crs_core_regs.v */
// crs_core_regs.v: programmer-visible registers of the 8-bit core
// assumes a decoder drives one-cycle op strobes and a data-space port
`timescale 1ns/10ps
`include "crs_consts.vh"
module crs_core_regs #(
	parameter DW = `CRS_DW,
	parameter PCW = `CRS_PCW,
	parameter DEPTH = `CRS_DEPTH
) (
	// clock, reset, enable
	input wire CLK,
	input wire RESETN,
	input wire CE,
	// data-space access port
	input wire [7:0] DS_ADDR,
	input wire DS_WR,
	input wire [DW-1:0] DS_WDATA,
	input wire DS_RD,
	output reg [DW-1:0] DS_RDATA,
	output reg DS_HIT,
	// accumulator datapath write
	input wire ACC_WR,
	input wire [DW-1:0] ACC_WDATA,
	// program counter control
	input wire [2:0] PC_OP,
	input wire [PCW-1:0] PC_TARGET,
	input wire [PCW-1:0] REL_OFFSET,
	input wire [PCW-1:0] IRQ_VECTOR,
	input wire [PCW-1:0] NMI_VECTOR,
	input wire IRET,
	// flag updates from the ALU
	input wire ARITH_UPD,
	input wire ARITH_CARRY,
	input wire LOGIC_UPD,
	input wire [DW-1:0] RESULT,
	input wire BITTEST_UPD,
	input wire BITTEST_VAL,
	// register views
	output reg [DW-1:0] ACC,
	output reg [DW-1:0] PTR0,
	output reg [DW-1:0] PTR1,
	output reg [DW-1:0] SD0,
	output reg [DW-1:0] SD1,
	output reg [PCW-1:0] PROGRAM_COUNTER,
	output reg CARRY,
	output reg ZERO,
	output reg [1:0] CTX,
	output reg [3:0] STACK_DEPTH,
	output reg STACK_EMPTY
);
	reg [DW-1:0] acc_reg, ptr0_reg, ptr1_reg, sd0_reg, sd1_reg;
	reg [PCW-1:0] pc_reg, pc_next;
	reg carry_normal_ctx, zero_normal_ctx;
	reg carry_irq_ctx, zero_irq_ctx;
	reg carry_nonmask_ctx, zero_nonmask_ctx;
	reg [1:0] ctx_reg, ctx_next;
	reg [1:0] prev_ctx_reg;
	reg [1:0] saved_ctx_reg;
	reg c_next, z_next, c_cur, z_cur;
	wire push, pop;
	wire [PCW-1:0] stk_top;
	wire [3:0] stk_depth;

	// 12-bit adder shared by increment, relative branch and the empty-stack return
	function [PCW-1:0] pc_add;
		input [PCW-1:0] a;
		input [PCW-1:0] b;
		begin
			pc_add = a + b;
		end
	endfunction

	// zero detect used for arithmetic and logic results
	function is_zero;
		input [DW-1:0] v;
		begin
			is_zero = (v == `CRS_ZERO8);
		end
	endfunction

	// empty test shared by the return path and the status view
	function stk_is_empty;
		input [3:0] d;
		begin
			stk_is_empty = (d == 4'h0);
		end
	endfunction

	// write strobe aimed at one mapped data-space address
	function ds_wr_at;
		input [7:0] a;
		begin
			ds_wr_at = DS_WR && (DS_ADDR == a);
		end
	endfunction

	// call and interrupt acceptance push; return ops pop
	assign push = (PC_OP == `CRS_PC_CALL) || (PC_OP == `CRS_PC_IRQ) ||
		(PC_OP == `CRS_PC_NMI);
	assign pop = (PC_OP == `CRS_PC_RET);

	// only return addresses enter the stack
	crs_stack #(
		.W(PCW),
		.DEPTH(DEPTH)
	) u_stack (
		.clk(CLK),
		.resetn(RESETN),
		.ce(CE),
		.push(push),
		.push_data(pc_reg),
		.pop(pop),
		.top_reg(stk_top),
		.depth_reg(stk_depth)
	);

	// program counter source select; stays 12 bits, banking is outside
	always @* begin
		pc_next = pc_reg;
		case (PC_OP)
			`CRS_PC_HOLD: pc_next = pc_reg;
			`CRS_PC_INC: pc_next = pc_add(pc_reg, `CRS_PC_STEP);
			`CRS_PC_JUMP: pc_next = PC_TARGET;
			`CRS_PC_CALL: pc_next = PC_TARGET;
			`CRS_PC_REL: pc_next = pc_add(pc_reg, REL_OFFSET);
			`CRS_PC_IRQ: pc_next = IRQ_VECTOR;
			`CRS_PC_NMI: pc_next = NMI_VECTOR;
			// empty stack: fall through to next instruction
			`CRS_PC_RET: pc_next = stk_is_empty(stk_depth) ?
				pc_add(pc_reg, `CRS_PC_STEP) : stk_top;
			default: pc_next = pc_reg;
		endcase
	end

	// vector load is the only reset path; no bank bits live here
	// pc register, reset vector on reset
	always @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			pc_reg <= `CRS_RESET_VECTOR;
		end else if (CE) begin
			pc_reg <= pc_next;
		end
	end

	// context selection: events pick their pair, return with IRET restores
	always @* begin
		ctx_next = ctx_reg;
		case (PC_OP)
			`CRS_PC_IRQ: ctx_next = `CRS_CTX_IRQ;
			`CRS_PC_NMI: ctx_next = `CRS_CTX_NMI;
			`CRS_PC_RET: begin
				if (IRET)
					ctx_next = prev_ctx_reg;
			end
			default: ctx_next = ctx_reg;
		endcase
	end

	// two levels of context history; nmi over irq keeps irq as the
	// state to return to, nesting deeper than two is not tracked by hardware
	always @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			ctx_reg <= `CRS_CTX_NMI;
			prev_ctx_reg <= `CRS_CTX_NORM;
			saved_ctx_reg <= `CRS_CTX_NORM;
		end else if (CE) begin
			ctx_reg <= ctx_next;
			if (PC_OP == `CRS_PC_IRQ || PC_OP == `CRS_PC_NMI) begin
				prev_ctx_reg <= ctx_reg;
				saved_ctx_reg <= prev_ctx_reg;
			end else if (PC_OP == `CRS_PC_RET && IRET) begin
				prev_ctx_reg <= saved_ctx_reg;
				saved_ctx_reg <= `CRS_CTX_NORM;
			end
		end
	end

	// active pair as seen by the ALU
	always @* begin
		case (ctx_reg)
			`CRS_CTX_NORM: begin
				c_cur = carry_normal_ctx;
				z_cur = zero_normal_ctx;
			end
			`CRS_CTX_IRQ: begin
				c_cur = carry_irq_ctx;
				z_cur = zero_irq_ctx;
			end
			default: begin
				c_cur = carry_nonmask_ctx;
				z_cur = zero_nonmask_ctx;
			end
		endcase
	end

	// flag next values from the alu events
	always @* begin
		c_next = c_cur;
		z_next = z_cur;
		if (ARITH_UPD) begin
			c_next = ARITH_CARRY;
			z_next = is_zero(RESULT);
		end else if (LOGIC_UPD) begin
			z_next = is_zero(RESULT);
		end else if (BITTEST_UPD) begin
			c_next = BITTEST_VAL;
		end
	end

	// hazard: a switch and an update in one cycle write the old pair
	// only the active pair is written; others keep their values
	always @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			carry_normal_ctx <= 1'b0;
			zero_normal_ctx <= 1'b0;
			carry_irq_ctx <= 1'b0;
			zero_irq_ctx <= 1'b0;
			carry_nonmask_ctx <= 1'b0;
			zero_nonmask_ctx <= 1'b0;
		end else if (CE) begin
			case (ctx_reg)
				`CRS_CTX_NORM: begin
					carry_normal_ctx <= c_next;
					zero_normal_ctx <= z_next;
				end
				`CRS_CTX_IRQ: begin
					carry_irq_ctx <= c_next;
					zero_irq_ctx <= z_next;
				end
				default: begin
					carry_nonmask_ctx <= c_next;
					zero_nonmask_ctx <= z_next;
				end
			endcase
		end
	end

	// data registers; data-space write wins over datapath write to the
	// accumulator since the same physical register is shared
	// unmapped addresses fall through untouched, nothing else is held
	always @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			acc_reg <= `CRS_ZERO8;
			ptr0_reg <= `CRS_ZERO8;
			ptr1_reg <= `CRS_ZERO8;
			sd0_reg <= `CRS_ZERO8;
			sd1_reg <= `CRS_ZERO8;
		end else if (CE) begin
			if (ds_wr_at(`CRS_ADDR_ACC))
				acc_reg <= DS_WDATA;
			else if (ACC_WR)
				acc_reg <= ACC_WDATA;
			if (ds_wr_at(`CRS_ADDR_PTR0))
				ptr0_reg <= DS_WDATA;
			if (ds_wr_at(`CRS_ADDR_PTR1))
				ptr1_reg <= DS_WDATA;
			if (ds_wr_at(`CRS_ADDR_SD0))
				sd0_reg <= DS_WDATA;
			if (ds_wr_at(`CRS_ADDR_SD1))
				sd1_reg <= DS_WDATA;
		end
	end

	// strobes last one cycle, so the answer returns to zero after
	// registered read port; other addresses answer zero, no hit
	always @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			DS_RDATA <= `CRS_ZERO8;
			DS_HIT <= 1'b0;
		end else if (CE) begin
			DS_HIT <= 1'b0;
			DS_RDATA <= `CRS_ZERO8;
			if (DS_RD) begin
				DS_HIT <= 1'b1;
				case (DS_ADDR)
					`CRS_ADDR_ACC: DS_RDATA <= acc_reg;
					`CRS_ADDR_PTR0: DS_RDATA <= ptr0_reg;
					`CRS_ADDR_PTR1: DS_RDATA <= ptr1_reg;
					`CRS_ADDR_SD0: DS_RDATA <= sd0_reg;
					`CRS_ADDR_SD1: DS_RDATA <= sd1_reg;
					default: DS_HIT <= 1'b0;
				endcase
			end
		end
	end

	// the lag costs a cycle of visibility but keeps every pin a flop
	// output views, each from a flip-flop, one cycle behind state
	always @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			ACC <= `CRS_ZERO8;
			PTR0 <= `CRS_ZERO8;
			PTR1 <= `CRS_ZERO8;
			SD0 <= `CRS_ZERO8;
			SD1 <= `CRS_ZERO8;
			PROGRAM_COUNTER <= `CRS_RESET_VECTOR;
			CARRY <= 1'b0;
			ZERO <= 1'b0;
			CTX <= `CRS_CTX_NMI;
			STACK_DEPTH <= 4'h0;
			STACK_EMPTY <= 1'b1;
		end else if (CE) begin
			ACC <= acc_reg;
			PTR0 <= ptr0_reg;
			PTR1 <= ptr1_reg;
			SD0 <= sd0_reg;
			SD1 <= sd1_reg;
			PROGRAM_COUNTER <= pc_reg;
			CARRY <= c_cur;
			ZERO <= z_cur;
			CTX <= ctx_reg;
			STACK_DEPTH <= stk_depth;
			STACK_EMPTY <= stk_is_empty(stk_depth);
		end
	end
endmodule

/* File: verification/crs_core_regs_assertions.sv */
// crs_core_regs_assertions.sv: port-level checks of the register core
// assumes binding to crs_core_regs; outputs lag state by one clock
`timescale 1ns/10ps
module crs_chk (
	// clock and reset
	input logic CLK,
	input logic RESETN,
	input logic CE,
	// requests
	input logic [7:0] DS_ADDR,
	input logic DS_RD,
	input logic DS_WR,
	input logic [2:0] PC_OP,
	input logic [11:0] PC_TARGET,
	input logic [11:0] REL_OFFSET,
	input logic ARITH_UPD,
	input logic ARITH_CARRY,
	input logic [7:0] RESULT,
	// answers
	input logic [7:0] DS_RDATA,
	input logic DS_HIT,
	input logic [7:0] PTR0,
	input logic [11:0] PROGRAM_COUNTER,
	input logic CARRY,
	input logic ZERO,
	input logic [1:0] CTX,
	input logic STACK_EMPTY,
	input logic [3:0] STACK_DEPTH
);
	// one domain, so clock and reset are given once
	default clocking @(posedge CLK);
	endclocking
	default disable iff (!RESETN);
	a_pc_step: assert property (CE && PC_OP == 3'h1 ##1 CE |=>
		PROGRAM_COUNTER == $past(PROGRAM_COUNTER) + 12'h001)
		else $error("pc did not step by one");
	a_pc_jump: assert property (CE && PC_OP == 3'h2 ##1 CE |=>
		PROGRAM_COUNTER == $past(PC_TARGET, 2))
		else $error("jump target not loaded");
	a_pc_rel: assert property (CE && PC_OP == 3'h4 ##1 CE |=>
		PROGRAM_COUNTER == $past(PROGRAM_COUNTER) + $past(REL_OFFSET, 2))
		else $error("relative sum wrong");
	a_push_sat: assert property (CE && PC_OP == 3'h3 ##1 CE |=>
		STACK_DEPTH == ($past(STACK_DEPTH) == 4'h6 ? 4'h6 :
		$past(STACK_DEPTH) + 4'h1))
		else $error("stack depth wrong after call");
	a_pop_empty: assert property (CE && PC_OP == 3'h7 ##1
		CE && STACK_EMPTY |=> STACK_EMPTY &&
		PROGRAM_COUNTER == $past(PROGRAM_COUNTER) + 12'h001)
		else $error("empty return misbehaved");
	a_read_ptr: assert property (CE && DS_RD && !DS_WR &&
		DS_ADDR == 8'h80 |=> DS_HIT && DS_RDATA == PTR0)
		else $error("pointer read wrong");
	a_reset_state: assert property ($rose(RESETN) |->
		CTX == 2'h2 && PROGRAM_COUNTER == 12'hFFE && STACK_EMPTY)
		else $error("state after reset wrong");
	// ctx switches are kept out so the visible pair is the one updated
	a_arith_flag: assert property (CE && ARITH_UPD && PC_OP < 3'h5
		##1 CE && PC_OP < 3'h5 |=> CARRY == $past(ARITH_CARRY, 2) &&
		ZERO == ($past(RESULT, 2) == 8'h00))
		else $error("arith flags wrong");
endmodule
bind crs_core_regs crs_chk crs_chk_i (.*);

/* File: verification/tb_crs_core_regs.sv */
// tb_crs_core_regs.sv: directed bench for the core register set
// assumes inputs change at the falling edge, outputs lag one clock
`timescale 1ns/10ps
module tb_crs_core_regs;
	logic CLK, RESETN, CE, DS_WR, DS_RD, DS_HIT, ACC_WR, IRET;
	logic ARITH_UPD, ARITH_CARRY, LOGIC_UPD, BITTEST_UPD, BITTEST_VAL;
	logic CARRY, ZERO, STACK_EMPTY;
	logic [7:0] DS_ADDR, DS_WDATA, DS_RDATA, ACC_WDATA, RESULT;
	logic [7:0] ACC, PTR0, PTR1, SD0, SD1;
	logic [7:0] adr[5] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'hFF};
	logic [2:0] PC_OP;
	logic [1:0] CTX;
	logic [3:0] STACK_DEPTH;
	logic [11:0] PC_TARGET, REL_OFFSET, IRQ_VECTOR, NMI_VECTOR;
	logic [11:0] PROGRAM_COUNTER, pc;
	logic [11:0] stk[$];
	int mismatches, check_count, i;
	crs_core_regs crs_core_regs_i (.*);
	// 20 MHz clock
	initial CLK = 1'b0;
	always #25 CLK = ~CLK;
	task chk(input logic [39:0] seen, input logic [39:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %0t seen %h want %h", $time, seen, exp);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(negedge CLK);
	endtask
	task test_done;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// every access leaves an idle cycle so no strobe is set twice at once
	task wr(input logic [7:0] a, input logic [7:0] d);
		DS_ADDR = a;
		DS_WDATA = d;
		DS_WR = 1'b1;
		cyc(1);
		DS_WR = 1'b0;
		cyc(1);
	endtask
	task rd(input logic [7:0] a, input logic [7:0] d, input logic h);
		DS_ADDR = a;
		DS_RD = 1'b1;
		cyc(1);
		chk(DS_RDATA, d);
		chk(DS_HIT, h);
		DS_RD = 1'b0;
		cyc(1);
		chk(DS_HIT, 1'b0);
	endtask
	// pc op with a reference model of pc and the shifting stack
	task op(input logic [2:0] o);
		PC_OP = o;
		cyc(1);
		PC_OP = 3'h0;
		cyc(1);
		if (o == 3'h7) pc = stk.size() ? stk.pop_front() : pc + 12'h001;
		if (o == 3'h1) pc = pc + 12'h001;
		if (o == 3'h4) pc = pc + REL_OFFSET;
		if (o inside {3'h3, 3'h5, 3'h6}) stk.push_front(pc);
		if (stk.size() > 6) stk = stk[0:5];
		if (o == 3'h2 || o == 3'h3) pc = PC_TARGET;
		if (o == 3'h5) pc = IRQ_VECTOR;
		if (o == 3'h6) pc = NMI_VECTOR;
		chk(PROGRAM_COUNTER, pc);
		chk(STACK_DEPTH, 40'(stk.size()));
	endtask
	// flag event: u is {arith, logic, bittest}
	task fl(input logic [2:0] u, input logic c, input logic [7:0] r,
		input logic ec, input logic ez);
		{ARITH_UPD, LOGIC_UPD, BITTEST_UPD} = u;
		ARITH_CARRY = c;
		BITTEST_VAL = c;
		RESULT = r;
		cyc(1);
		{ARITH_UPD, LOGIC_UPD, BITTEST_UPD} = 3'h0;
		cyc(1);
		chk({CARRY, ZERO}, {ec, ez});
	endtask
	// watchdog: tests need under a hundred cycles, allow 2000
	initial begin
		#100000;
		mismatches++;
		test_done;
	end
	initial begin
		{DS_WR, DS_RD, ACC_WR, IRET, ARITH_UPD, ARITH_CARRY} = 6'h00;
		{LOGIC_UPD, BITTEST_UPD, BITTEST_VAL, RESETN, CE} = 5'h01;
		{DS_ADDR, DS_WDATA, ACC_WDATA, RESULT, PC_OP} = 35'h0;
		{PC_TARGET, REL_OFFSET} = 24'h0;
		IRQ_VECTOR = 12'h3A0;
		NMI_VECTOR = 12'h5C0;
		pc = 12'hFFE;
		cyc(5);
		RESETN = 1'b1;
		chk({PROGRAM_COUNTER, STACK_EMPTY}, 13'h1FFD);
		chk(CTX, 2'h2);
		$display("test reset done");
		for (i = 0; i < 5; i++) wr(adr[i], 8'hA5 ^ i[7:0]);
		for (i = 0; i < 5; i++)
			rd(adr[i], 8'hA5 ^ i[7:0], 1'b1);
		chk({PTR0, PTR1, SD0, SD1, ACC}, 40'hA5A4A7A6A1);
		wr(8'h84, 8'h3C);
		rd(8'h84, 8'h00, 1'b0);
		ACC_WDATA = 8'h5E;
		ACC_WR = 1'b1;
		cyc(1);
		ACC_WR = 1'b0;
		cyc(1);
		rd(8'hFF, 8'h5E, 1'b1);
		$display("test registers done");
		op(3'h1);
		op(3'h1);
		PC_TARGET = 12'h123;
		op(3'h2);
		REL_OFFSET = 12'h010;
		op(3'h4);
		REL_OFFSET = 12'hFFD;
		op(3'h4);
		$display("test pc done");
		for (i = 0; i < 7; i++) begin
			PC_TARGET = 12'h200 + i[11:0];
			op(3'h3);
		end
		for (i = 0; i < 7; i++) op(3'h7);
		chk({ACC, STACK_EMPTY}, 9'h0BD);
		$display("test stack done");
		fl(3'h4, 1'b1, 8'h00, 1'b1, 1'b1);
		op(3'h5);
		chk({CTX, CARRY, ZERO}, 4'h4);
		fl(3'h2, 1'b1, 8'h05, 1'b0, 1'b0);
		fl(3'h1, 1'b1, 8'h00, 1'b1, 1'b0);
		op(3'h6);
		chk({CTX, CARRY, ZERO}, 4'hB);
		IRET = 1'b1;
		op(3'h7);
		IRET = 1'b0;
		chk({CTX, CARRY, ZERO}, 4'h6);
		fl(3'h4, 1'b0, 8'h80, 1'b0, 1'b0);
		$display("test flags done");
		test_done;
	end
endmodule
